// File: common/bstap_defines.vh
`ifndef BSTAP_DEFINES_VH
`define BSTAP_DEFINES_VH

// ****************************************
// TAP states, one-hot
// ****************************************
`define BSTAP_ST_W         16
`define BSTAP_TLR          16'h0001
`define BSTAP_RTI          16'h0002
`define BSTAP_SEL_DR       16'h0004
`define BSTAP_CAP_DR       16'h0008
`define BSTAP_SHF_DR       16'h0010
`define BSTAP_EX1_DR       16'h0020
`define BSTAP_PAU_DR       16'h0040
`define BSTAP_EX2_DR       16'h0080
`define BSTAP_UPD_DR       16'h0100
`define BSTAP_SEL_IR       16'h0200
`define BSTAP_CAP_IR       16'h0400
`define BSTAP_SHF_IR       16'h0800
`define BSTAP_EX1_IR       16'h1000
`define BSTAP_PAU_IR       16'h2000
`define BSTAP_EX2_IR       16'h4000
`define BSTAP_UPD_IR       16'h8000

// ****************************************
// Instruction codes and capture pattern
// ****************************************
`define BSTAP_IR_W         3
`define BSTAP_INS_EXTEST   3'h0
`define BSTAP_INS_IDCODE   3'h1
`define BSTAP_INS_SAMPLEZ  3'h2
`define BSTAP_INS_SAMPLE   3'h4
`define BSTAP_INS_BYPASS   3'h7
`define BSTAP_IR_CAPTURE   2'h1
`define BSTAP_ID_W         32
`define BSTAP_RESET_ONES   5

`endif

// File: rtl/bstap_port.v
`timescale 1ns/10ps
`include "bstap_defines.vh"

module bstap_port #(
    parameter [31:0] ID_CODE  = 32'h0000_0001, // Arbitrary identity value
    parameter        BSR_LEN  = 8              // Boundary register length
) (
    input  wire               i_ref_clk,     // System clock, 20 MHz
    input  wire               i_reset,       // Power-up reset, sync, high
    input  wire               i_clk_en,      // Clock enable, freezes state
    input  wire               i_tck,         // Test clock pin
    input  wire               i_tms,         // Mode select pin
    input  wire               i_tms_drv,     // High when mode select driven
    input  wire               i_tdi,         // Serial data input pin
    input  wire               i_tdi_drv,     // High when data input driven
    input  wire [BSR_LEN-1:0] i_pins,        // Pin levels for capture
    output reg                o_tdo,         // Serial data output
    output reg                o_tdo_oe,      // Serial output enable
    output reg  [2:0]         o_instr,       // Active instruction
    output reg                o_outputs_off  // Memory outputs forced off
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    reg [4:0]         sync1_reg;             // First stage, read by stage two only
    reg [4:0]         sync2_reg;             // Second stage
    reg               tck_d_reg;             // Last test clock level
    reg [BSR_LEN-1:0] pins_s1_reg;           // Pin levels, first stage
    reg [BSR_LEN-1:0] pins_s2_reg;           // Pin levels, second stage

    // Stage order: tck, tms, tdi, mode driven, data driven
    wire      tms_eff  = sync2_reg[1] | ~sync2_reg[3]; // Float reads one
    wire      tdi_eff  = sync2_reg[2] | ~sync2_reg[4]; // Float reads one
    wire      tck_rise = sync2_reg[0] & ~tck_d_reg;    // Rising test edge
    wire      tck_fall = ~sync2_reg[0] & tck_d_reg;    // Falling test edge

    // ****************************************
    // State and shift registers
    // ****************************************
    reg [`BSTAP_ST_W-1:0] state_reg;         // One-hot TAP state
    reg [`BSTAP_ST_W-1:0] state_next;        // Next TAP state
    reg [`BSTAP_IR_W-1:0] ir_shift_reg;      // Instruction shift stage
    reg [`BSTAP_ID_W-1:0] id_shift_reg;      // Identity shift stage
    reg [BSR_LEN-1:0]     bsr_reg;           // Boundary scan register
    reg                   byp_reg;           // Bypass bit
    reg [2:0]             tms_run_reg;       // Count of high mode samples
    reg [`BSTAP_IR_W-1:0] instr_next;        // Instruction for next fall

    // ****************************************
    // Synchronise pins into system clock
    // ****************************************
    always @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            sync1_reg   <= 5'h1e;            // Test clock idles low
            sync2_reg   <= 5'h1e;
            tck_d_reg   <= 1'b0;             // No false edge after reset
            pins_s1_reg <= {BSR_LEN{1'b0}};
            pins_s2_reg <= {BSR_LEN{1'b0}};
        end
        else if (i_clk_en)
        begin
            sync1_reg   <= {i_tdi_drv, i_tms_drv, i_tdi, i_tms, i_tck};
            sync2_reg   <= sync1_reg;
            tck_d_reg   <= sync2_reg[0];
            pins_s1_reg <= i_pins;
            pins_s2_reg <= pins_s1_reg;
        end
    end

    // ****************************************
    // Next state decode
    // ****************************************
    always @*
    begin
        state_next = `BSTAP_TLR;
        case (state_reg)                       // Standard sequence
            `BSTAP_TLR:    state_next = tms_eff ? `BSTAP_TLR    : `BSTAP_RTI;
            `BSTAP_RTI:    state_next = tms_eff ? `BSTAP_SEL_DR : `BSTAP_RTI;
            `BSTAP_SEL_DR: state_next = tms_eff ? `BSTAP_SEL_IR : `BSTAP_CAP_DR;
            `BSTAP_CAP_DR: state_next = tms_eff ? `BSTAP_EX1_DR : `BSTAP_SHF_DR;
            `BSTAP_SHF_DR: state_next = tms_eff ? `BSTAP_EX1_DR : `BSTAP_SHF_DR;
            `BSTAP_EX1_DR: state_next = tms_eff ? `BSTAP_UPD_DR : `BSTAP_PAU_DR;
            `BSTAP_PAU_DR: state_next = tms_eff ? `BSTAP_EX2_DR : `BSTAP_PAU_DR;
            `BSTAP_EX2_DR: state_next = tms_eff ? `BSTAP_UPD_DR : `BSTAP_SHF_DR;
            `BSTAP_UPD_DR: state_next = tms_eff ? `BSTAP_SEL_DR : `BSTAP_RTI;
            `BSTAP_SEL_IR: state_next = tms_eff ? `BSTAP_TLR    : `BSTAP_CAP_IR;
            `BSTAP_CAP_IR: state_next = tms_eff ? `BSTAP_EX1_IR : `BSTAP_SHF_IR;
            `BSTAP_SHF_IR: state_next = tms_eff ? `BSTAP_EX1_IR : `BSTAP_SHF_IR;
            `BSTAP_EX1_IR: state_next = tms_eff ? `BSTAP_UPD_IR : `BSTAP_PAU_IR;
            `BSTAP_PAU_IR: state_next = tms_eff ? `BSTAP_EX2_IR : `BSTAP_PAU_IR;
            `BSTAP_EX2_IR: state_next = tms_eff ? `BSTAP_UPD_IR : `BSTAP_SHF_IR;
            `BSTAP_UPD_IR: state_next = tms_eff ? `BSTAP_SEL_DR : `BSTAP_RTI;
            default:       state_next = `BSTAP_TLR;  // Illegal code recovers
        endcase
    end

    // Selected data register's serial end
    function sel_dr_bit;
        input [2:0]           ins;
        input [`BSTAP_ID_W-1:0] idr;
        input [BSR_LEN-1:0]   bsr;
        input                 byp;
        begin
            case (ins)
                `BSTAP_INS_IDCODE:  sel_dr_bit = idr[0];
                `BSTAP_INS_EXTEST,
                `BSTAP_INS_SAMPLEZ,
                `BSTAP_INS_SAMPLE:  sel_dr_bit = bsr[0];
                default:            sel_dr_bit = byp;
            endcase
        end
    endfunction

    // Instruction that the next falling edge installs
    always @*
    begin
        instr_next = o_instr;                  // Hold by default
        if (state_reg == `BSTAP_TLR)
            instr_next = `BSTAP_INS_IDCODE;    // Reset state reloads identity
        else if (state_reg == `BSTAP_UPD_IR)
            instr_next = ir_shift_reg;         // Only at update
    end

    // ****************************************
    // Rising edge: state, capture and shift
    // ****************************************
    always @(posedge i_ref_clk)
    begin
        if (i_reset)                           // Power-up only, no test reset
        begin
            state_reg    <= `BSTAP_TLR;
            ir_shift_reg <= `BSTAP_INS_IDCODE;
            id_shift_reg <= 32'h0000_0000;
            bsr_reg      <= {BSR_LEN{1'b0}};
            byp_reg      <= 1'b0;
            tms_run_reg  <= 3'h0;
        end
        else if (i_clk_en && tck_rise)         // Inputs taken on rising edge
        begin
            // Five high samples always land in reset
            if (!tms_eff)
                tms_run_reg <= 3'h0;
            else if (tms_run_reg != 3'h7)
                tms_run_reg <= tms_run_reg + 3'h1;
            if (tms_eff && tms_run_reg >= 3'h4)
                state_reg <= `BSTAP_TLR;
            else
                state_reg <= state_next;
            case (state_reg)
                `BSTAP_CAP_IR:
                    ir_shift_reg <= {ir_shift_reg[2], `BSTAP_IR_CAPTURE};
                `BSTAP_SHF_IR:
                    ir_shift_reg <= {tdi_eff, ir_shift_reg[2:1]};
                `BSTAP_CAP_DR:
                begin
                    id_shift_reg <= ID_CODE;
                    bsr_reg      <= pins_s2_reg;
                    byp_reg      <= 1'b0;
                end
                `BSTAP_SHF_DR:
                begin
                    id_shift_reg <= {tdi_eff, id_shift_reg[`BSTAP_ID_W-1:1]};
                    bsr_reg      <= {tdi_eff, bsr_reg[BSR_LEN-1:1]};
                    byp_reg      <= tdi_eff;
                end
                default:
                    ;                           // Other states hold shifters
            endcase
        end
    end

    // ****************************************
    // Falling edge: outputs and instruction
    // ****************************************
    always @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            o_tdo         <= 1'b1;
            o_tdo_oe      <= 1'b0;              // Quiet until clocked
            o_instr       <= `BSTAP_INS_IDCODE;
            o_outputs_off <= 1'b0;
        end
        else if (i_clk_en && tck_fall)         // Outputs move on falling edge
        begin
            o_instr       <= instr_next;
            // Follows the instruction being installed, not the old one
            o_outputs_off <= (instr_next == `BSTAP_INS_SAMPLEZ);
            if (state_reg == `BSTAP_SHF_IR)
            begin
                o_tdo    <= ir_shift_reg[0];
                o_tdo_oe <= 1'b1;
            end
            else if (state_reg == `BSTAP_SHF_DR)
            begin
                o_tdo    <= sel_dr_bit(o_instr, id_shift_reg, bsr_reg, byp_reg);
                o_tdo_oe <= 1'b1;
            end
            else
            begin
                o_tdo    <= 1'b1;
                o_tdo_oe <= 1'b0;
            end
        end
    end

endmodule // bstap_port

// File: tb/bstap_port_chk.sv
`timescale 1ns/10ps
// ****************
// Port checker
// ****************
module bstap_port_chk (
    input wire       i_ref_clk,    // Clock
    input wire       i_reset,      // Reset
    input wire       i_tck,        // Test clock
    input wire       i_tms,        // Mode select
    input wire       i_tms_drv,    // Mode driven
    input wire       i_clk_en,     // Clock enable
    input wire       o_tdo,        // Serial out
    input wire       o_tdo_oe,     // Out enable
    input wire [2:0] o_instr,      // Instruction
    input wire       o_outputs_off // Outputs off
);
    reg       tck_reg;  // Last test clock
    reg [2:0] ones_reg; // High mode samples
    wire      tms_eff = i_tms | ~i_tms_drv; // Floating reads one
    wire      tck_rise = i_tck & ~tck_reg;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    // Count consecutive high mode samples
    always @(posedge i_ref_clk)
    begin
        tck_reg <= i_tck;
        if (i_reset) ones_reg <= 3'h0;
        else if (tck_rise && i_clk_en)
            ones_reg <= tms_eff ? ones_reg + {2'h0, ones_reg != 3'h5} : 3'h0;
    end
    AST_TDO_IDLE: assert property (!o_tdo_oe |-> o_tdo)
        else $error("serial out not idle");
    AST_INSTR_FALL: assert property ($changed(o_instr) |-> !$past(i_tck, 3) && $past(i_tck, 5))
        else $error("instruction moved off the fall");
    AST_OE_FALL: assert property ($changed(o_tdo_oe) |-> !$past(i_tck, 3) && $past(i_tck, 5))
        else $error("enable moved off the fall");
    AST_RESET_VAL: assert property (disable iff (1'b0) i_reset |=> o_instr == 3'h1 && !o_tdo_oe)
        else $error("bad reset values");
    AST_IDLE_HOLD: assert property (!i_tck [*8] |=> $stable(o_instr) && $stable(o_tdo_oe))
        else $error("outputs moved without clock");
    AST_FIVE_ONES: assert property (tck_rise && tms_eff && ones_reg == 3'h4 |-> ##[1:14] (o_instr == 3'h1 && !o_tdo_oe))
        else $error("no reset after five ones");
    AST_INSTR_NOSHIFT: assert property ($changed(o_instr) |-> !o_tdo_oe)
        else $error("instruction changed while shifting");
    AST_OFF_SAMPZ: assert property (o_outputs_off |-> o_instr == 3'h2)
        else $error("outputs off without sample-z");
    AST_CEN_FREEZE: assert property (!i_clk_en |=> $stable(o_instr) && $stable(o_tdo_oe) && $stable(o_tdo))
        else $error("outputs moved while clock enable low");
endmodule // bstap_port_chk
bind bstap_port bstap_port_chk u_chk (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_tck(i_tck),
    .i_tms(i_tms), .i_tms_drv(i_tms_drv), .i_clk_en(i_clk_en), .o_tdo(o_tdo),
    .o_tdo_oe(o_tdo_oe), .o_instr(o_instr), .o_outputs_off(o_outputs_off));

// File: tb/bstap_tester.sv
`timescale 1ns/10ps
// ****************
// Boundary-scan controller model
// ****************
module bstap_tester (
    input  wire i_ref_clk, // System clock
    input  wire i_step,    // Start one test clock period
    input  wire i_tms,     // Mode value to send
    input  wire i_tdi,     // Data value to send
    input  wire i_drv,     // Low floats both pins
    input  wire i_tdo,     // Serial out from device
    input  wire i_tdo_oe,  // Serial out enable
    output reg  o_tck,     // Test clock, still between periods
    output reg  o_tms,     // Mode select pin
    output reg  o_tdi,     // Data input pin
    output reg  o_drv,     // Pins driven
    output reg  o_done,    // Period finished
    output reg  o_seen     // Serial out level on the wire
);
    reg [3:0] cnt_reg = 4'h0;  // Phase counter
    reg       busy_reg = 1'b0; // Period running
    initial {o_tck, o_tms, o_tdi, o_drv, o_done, o_seen} = 6'h1d;
    // Four cycles low, four high, sample before the fall
    always @(posedge i_ref_clk)
    begin
        o_done <= 1'b0;
        if (!busy_reg && i_step)
        begin
            busy_reg <= 1'b1;
            cnt_reg  <= 4'h0;
            o_drv    <= i_drv;
            o_tms    <= i_drv ? i_tms : ~i_tms;
            o_tdi    <= i_drv ? i_tdi : ~i_tdi;
        end
        else if (busy_reg)
        begin
            cnt_reg <= cnt_reg + 4'h1;
            o_tck   <= cnt_reg >= 4'h3 && cnt_reg < 4'h7;
            if (cnt_reg == 4'h7)
            begin
                busy_reg <= 1'b0;
                o_done   <= 1'b1;
                o_seen   <= i_tdo_oe ? i_tdo : ~o_seen; // Released line
            end
        end
    end
endmodule // bstap_tester

// File: tb/test_boundary_scan_tap_port.sv
`timescale 1ns/10ps
module test_boundary_scan_tap_port;
    reg          clk = 1'b0, rst = 1'b1, stp = 1'b0, tms = 1'b1, tdi = 1'b1, drv = 1'b1;
    reg  [7:0]   pins = 8'h00;   // Pin levels for capture
    reg          cen = 1'b1;     // Clock enable to the design
    logic [63:0] sv, kv;         // Model saved across a frozen period
    wire         tck, ptms, ptdi, pdrv, done, seen, tdo, oe, off;
    wire [2:0]   ins;            // Active instruction
    int          err_count = 0, num_checks = 0, st = 0, len = 1, i, k;
    int          n0[16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
    int          n1[16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
    logic [63:0] sr = 64'h0, km = 64'h0;  // Model shift path and known bits
    logic [2:0]  act = 3'h1, c;
    logic [2:0]  codes[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    logic        ak = 1'b1, dk = 1'b1;
    logic [31:0] rng = 32'd18, r;
    localparam [31:0] ID = 32'h0000_0001; // Arbitrary identity value
    always #25 clk = ~clk;
    bstap_tester u_tst (.i_ref_clk(clk), .i_step(stp), .i_tms(tms), .i_tdi(tdi), .i_drv(drv),
        .i_tdo(tdo), .i_tdo_oe(oe), .o_tck(tck), .o_tms(ptms), .o_tdi(ptdi), .o_drv(pdrv),
        .o_done(done), .o_seen(seen));
    bstap_port #(.ID_CODE(ID), .BSR_LEN(8)) dut (.i_ref_clk(clk), .i_reset(rst), .i_clk_en(cen),
        .i_tck(tck), .i_tms(ptms), .i_tms_drv(pdrv), .i_tdi(ptdi), .i_tdi_drv(pdrv), .i_pins(pins),
        .o_tdo(tdo), .o_tdo_oe(oe), .o_instr(ins), .o_outputs_off(off));
    function logic [31:0] rnd();
        rng ^= rng << 13; rng ^= rng >> 17; rng ^= rng << 5;
        return rng;
    endfunction
    task chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1) begin err_count++; $display("[ERR] %0t %s", $time, m); end
    endtask
    task complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One test clock period, then compare and advance the model
    task step(input logic t, input logic d, input logic v);
        int n; logic e, et;
        begin
            r = rnd();
            @(posedge clk); stp <= 1'b1; tms <= t; tdi <= d; drv <= v; pins <= r[7:0];
            @(posedge clk); stp <= 1'b0;
            for (n = 0; n < 20 && done !== 1'b1; n++) @(negedge clk);
            if (n == 20) begin chk(1'b0, "no period end"); complete_run(); end
            chk(oe === (st == 4 || st == 11), "enable");
            if (ak) chk(ins === act && off === (act == 3'h2), "instruction");
            if (oe === 1'b1 && km[0] && (dk || st == 11)) chk(seen === sr[0], "serial out");
            e = v ? d : 1'b1;
            et = v ? t : 1'b1;
            if (st == 3)
            begin
                dk = ak; len = 32; sr = {32'h0, ID}; km = 64'hffff_ffff;
                if (act != 3'h1) begin len = 1; sr = 64'h0; km = 64'h1; end
                if (act == 3'h0 || act == 3'h2 || act == 3'h4) begin len = 8; sr = {56'h0, pins}; km = 64'hff; end
            end
            if (st == 10) begin sr = 64'h1; km = 64'h3; len = 3; end
            if (st == 4 || st == 11) begin sr = sr >> 1; km = km >> 1; sr[len-1] = e; km[len-1] = 1'b1; end
            st = et ? n1[st] : n0[st];
            if (st == 15) begin act = sr[2:0]; ak = &km[2:0]; end
            if (st == 0) begin act = 3'h1; ak = 1'b1; end
        end
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (40) @(posedge clk);
        for (i = 0; i < 5; i++) step(1, 1, 1);
        $display("power-up test done");
        for (k = 0; k < 6; k++)
        begin
            c = codes[k];
            step(0, 1, 1); step(1, 1, 1); step(1, 1, 1); step(0, 1, 1); step(0, 1, 1);
            for (i = 0; i < 3; i++) step(i == 2, c[i], 1);
            step(1, 1, 1); step(1, 1, 1); step(0, 1, 1); step(0, 1, 1);
            for (i = 0; i < 34; i++) begin r = rnd(); step(i == 33, r[0], 1); end
            for (i = 0; i < 5; i++) step(1, 1, 1);
        end
        $display("instruction test done");
        for (i = 0; i < 400; i++) begin r = rnd(); step(r[1:0] == 2'h0, r[2], r[5:3] != 3'h0); end
        $display("random walk done");
        @(posedge clk) rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0; st = 0; act = 3'h1; ak = 1'b1;
        for (i = 0; i < 8; i++) step(i > 5, 1, 1);
        $display("second reset test done");
        step(0, 1, 1);
        step(0, 1, 1);
        repeat (4) @(posedge clk);
        cen <= 1'b0;
        k = st;
        sv = sr;
        kv = km;
        step(1, 0, 1);
        repeat (4) @(posedge clk);
        cen <= 1'b1;
        st = k;
        sr = sv;
        km = kv;
        for (i = 0; i < 8; i++) step(1, 1, 1);
        $display("clock enable test done");
        complete_run();
    end
endmodule // test_boundary_scan_tap_port
